// >>> vdc_host.sv
// Overview of operation
// - Dummy write transfer: write transfer with shift_port_enable high; array untouched.
// - Alternate write: function_select high, mask_or_write_enable low; enable ignored.
// - Serial input is stored only while shift_port_enable is low.
// - After 100 us of power, eight row_strobe cycles precede normal use.
// - Normal access: strobes high, function_select low at both falls.
// - One-shot masked write: mask on data pins at row_strobe fall.
// - Held masked write uses the stored mask register.
// - Block fill: normal levels at row fall, function_select high at column fall.
// - Masked block fills combine masked-write levels with block fill select.
// - Register loads: all three high at row fall; column select picks register.
// - Transfer kinds decoded from write enable, function select and shift_port_enable at row fall.
// - A normal read transfer must precede split read transfers.
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "vdc_cfg.svh"
module vdc_host #(
    parameter int PWR_CYC = `VDC_PWR_CYC,
    parameter int PHASE_CYC = `VDC_PHASE_CYC
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic row_strobe_n,
    output logic column_strobe_n,
    output logic transfer_or_output_enable_n,
    output logic mask_or_write_enable_n,
    output logic function_select,
    output logic shift_port_enable_n,
    output logic shift_clock,
    output logic [8:0] addr,
    input wire logic [3:0] dq_in,
    output logic [3:0] dq_out,
    output logic dq_oe_n,
    input wire logic [3:0] shift_data_in,
    output logic [3:0] shift_data_out,
    output logic shift_data_oe_n,
    input wire logic half_flag
);
    initial begin
        if (PWR_CYC < 1 || PHASE_CYC < 1 || PHASE_CYC > 255) begin
            $error("vdc_host: unsupported timing parameter");
        end
    end

    // Decode table: pin levels at the two strobe falls for each cycle kind.
    function automatic vdc_pkg::vdc_lvl_t lvl_of(input vdc_pkg::vdc_op_t op);
        vdc_pkg::vdc_lvl_t l;
        l = '{trn: 1'b1, men: 1'b1, fs_r: 1'b0, fs_c: 1'b0, sen: 1'b1,
              column_first_refresh: 1'b0, ras_only: 1'b0, wr: 1'b0, rd: 1'b0, mask_ras: 1'b0};
        unique case (op)
            vdc_pkg::OP_ROW_ONLY_REFRESH: l.ras_only = 1'b1;
            vdc_pkg::OP_COLUMN_FIRST_REFRESH: l.column_first_refresh = 1'b1;
            vdc_pkg::OP_READ: l.rd = 1'b1;
            vdc_pkg::OP_WRITE: l.wr = 1'b1;
            vdc_pkg::OP_ONE_SHOT_MASKED_WRITE: begin
                l.men = 1'b0;
                l.mask_ras = 1'b1;
            end
            vdc_pkg::OP_HELD_MASKED_WRITE: begin
                l.men = 1'b0;
                l.fs_r = 1'b1;
            end
            vdc_pkg::OP_BLOCK_FILL: l.fs_c = 1'b1;
            vdc_pkg::OP_ONE_SHOT_MASKED_BLOCK_FILL: begin
                l.men = 1'b0;
                l.mask_ras = 1'b1;
                l.fs_c = 1'b1;
            end
            vdc_pkg::OP_HELD_MASKED_BLOCK_FILL: begin
                l.men = 1'b0;
                l.fs_r = 1'b1;
                l.fs_c = 1'b1;
            end
            vdc_pkg::OP_LOAD_MASK: l.fs_r = 1'b1;
            vdc_pkg::OP_LOAD_COLOR: begin
                l.fs_r = 1'b1;
                l.fs_c = 1'b1;
            end
            vdc_pkg::OP_READ_XFER: l.trn = 1'b0;
            vdc_pkg::OP_SPLIT_READ_XFER: begin
                l.trn = 1'b0;
                l.fs_r = 1'b1;
            end
            vdc_pkg::OP_WRITE_XFER: begin
                l.trn = 1'b0;
                l.men = 1'b0;
                l.sen = 1'b0;
            end
            vdc_pkg::OP_DUMMY_WRITE_XFER: begin
                l.trn = 1'b0;
                l.men = 1'b0;
            end
            vdc_pkg::OP_ALT_WRITE_XFER: begin
                l.trn = 1'b0;
                l.men = 1'b0;
                l.fs_r = 1'b1;
            end
        endcase
        l.wr = l.wr || (l.trn && l.men && (l.fs_r || l.fs_c));
        return l;
    endfunction

    // The flag pin comes from the device, so it is synchronised first.
    logic hf_s1_ff, hf_s2_ff;
    logic [3:0] sdi_s1_ff, sdi_s2_ff, dqi_s1_ff, dqi_s2_ff;
    always_ff @(posedge ref_clk) begin
        hf_s1_ff <= half_flag;
        hf_s2_ff <= hf_s1_ff;
        sdi_s1_ff <= shift_data_in;
        sdi_s2_ff <= sdi_s1_ff;
        dqi_s1_ff <= dq_in;
        dqi_s2_ff <= dqi_s1_ff;
    end

    vdc_pkg::vdc_state_t st_ff, nxt_st;
    vdc_pkg::vdc_op_t op_ff, nxt_op;
    logic [31:0] pwr_ff, nxt_pwr;
    logic [3:0] init_ff, nxt_init;
    logic [7:0] cnt_ff, nxt_cnt;
    logic ready_ff, nxt_ready, rt_seen_ff, nxt_rt_seen, dir_in_ff, nxt_dir_in;
    logic refused_ff, nxt_refused;
    logic [31:0] addr_reg_ff, nxt_addr_reg;
    logic [7:0] data_reg_ff, nxt_data_reg;
    logic [3:0] rd_data_ff, nxt_rd_data, sin_ff, nxt_sin;
    logic sc_busy_ff, nxt_sc_busy, sc_en_ff, nxt_sc_en, sc_drv_ff, nxt_sc_drv;
    logic [7:0] sc_cnt_ff, nxt_sc_cnt;
    logic [3:0] sc_data_ff, nxt_sc_data;
    logic ras_n, nxt_ras_n, cas_n, nxt_cas_n, trn_n, nxt_trn_n, men_n, nxt_men_n;
    logic fsel, nxt_fsel, sen_n, nxt_sen_n, sclk, nxt_sclk, dqoe_n, nxt_dqoe_n;
    logic sdoe_n, nxt_sdoe_n;
    logic [8:0] addr_o, nxt_addr_o;
    logic [3:0] dq_o, nxt_dq_o, sd_o, nxt_sd_o;
    logic awr_ff, nxt_awr, bv_ff, nxt_bv, arr_ff, nxt_arr, rv_ff, nxt_rv;
    logic [31:0] rdat_ff, nxt_rdat;
    logic wr_go, go_ok;
    vdc_pkg::vdc_lvl_t lv;

    assign wr_go = s_axi_awvalid && s_axi_wvalid && !awr_ff && !bv_ff;
    assign lv = lvl_of(op_ff);
    // Split reads are refused until a normal read transfer set the direction.
    assign go_ok = ready_ff && st_ff == vdc_pkg::S_IDLE && !sc_busy_ff &&
        (vdc_pkg::vdc_op_t'(s_axi_wdata[3:0]) != vdc_pkg::OP_SPLIT_READ_XFER
         || rt_seen_ff);

    // Register slave, cycle sequencer and shift-clock pacer share one next-state block.
    always_comb begin
        nxt_st = st_ff; nxt_op = op_ff; nxt_pwr = pwr_ff; nxt_init = init_ff;
        nxt_cnt = cnt_ff; nxt_ready = ready_ff; nxt_rt_seen = rt_seen_ff;
        nxt_dir_in = dir_in_ff; nxt_refused = refused_ff;
        nxt_addr_reg = addr_reg_ff; nxt_data_reg = data_reg_ff;
        nxt_rd_data = rd_data_ff; nxt_sin = sin_ff; nxt_sc_busy = sc_busy_ff;
        nxt_sc_en = sc_en_ff; nxt_sc_drv = sc_drv_ff; nxt_sc_cnt = sc_cnt_ff;
        nxt_sc_data = sc_data_ff; nxt_ras_n = ras_n; nxt_cas_n = cas_n;
        nxt_trn_n = trn_n; nxt_men_n = men_n; nxt_fsel = fsel; nxt_sen_n = sen_n;
        nxt_sclk = sclk; nxt_dqoe_n = dqoe_n; nxt_sdoe_n = sdoe_n;
        nxt_addr_o = addr_o; nxt_dq_o = dq_o; nxt_sd_o = sd_o;
        nxt_awr = 1'b0; nxt_bv = bv_ff; nxt_arr = 1'b0; nxt_rv = rv_ff;
        nxt_rdat = rdat_ff;
        // Write side: address and data are taken together, response raised in the same cycle as the ready.
        if (bv_ff && s_axi_bready) nxt_bv = 1'b0;
        if (wr_go) begin
            nxt_awr = 1'b1;
            nxt_bv = 1'b1;
            unique case (s_axi_awaddr)
                `VDC_OFS_CTRL: begin
                    if (go_ok) begin
                        nxt_op = vdc_pkg::vdc_op_t'(s_axi_wdata[`VDC_CTRL_OP_LSB +: 4]);
                        nxt_st = vdc_pkg::S_RAS;
                        nxt_cnt = 8'(PHASE_CYC);
                    end
                    nxt_refused = !go_ok; // Each CTRL order rewrites it: a refused order sets it, a taken order clears it.
                end
                `VDC_OFS_ADDR: nxt_addr_reg = s_axi_wdata;
                `VDC_OFS_DATA: nxt_data_reg = s_axi_wdata[7:0];
                `VDC_OFS_SHIFT: begin
                    if (!sc_busy_ff && st_ff == vdc_pkg::S_IDLE) begin
                        nxt_sc_busy = 1'b1;
                        nxt_sc_cnt = 8'(PHASE_CYC);
                        nxt_sc_data = s_axi_wdata[3:0];
                        nxt_sc_en = s_axi_wdata[`VDC_SHIFT_EN_BIT];
                        nxt_sc_drv = s_axi_wdata[`VDC_SHIFT_DRV_BIT];
                    end
                end
                default: ;
            endcase
        end
        // Read side: one-cycle ready, data held until the master takes it.
        if (rv_ff && s_axi_rready) nxt_rv = 1'b0;
        if (s_axi_arvalid && !arr_ff && !rv_ff) begin
            nxt_arr = 1'b1;
            nxt_rv = 1'b1;
            unique case (s_axi_araddr)
                `VDC_OFS_ADDR: nxt_rdat = addr_reg_ff;
                `VDC_OFS_DATA: nxt_rdat = {24'h00_0000, data_reg_ff};
                `VDC_OFS_STAT: nxt_rdat = {20'h0_0000, sin_ff, rd_data_ff, refused_ff,
                    hf_s2_ff, ready_ff, st_ff != vdc_pkg::S_IDLE || sc_busy_ff};
                default: nxt_rdat = 32'h0000_0000;
            endcase
        end
        // Power-up wait, then eight row-only cycles before any CTRL order is taken.
        if (pwr_ff != 32'h0000_0000) begin
            nxt_pwr = pwr_ff - 32'h0000_0001;
        end else if (!ready_ff && st_ff == vdc_pkg::S_IDLE) begin
            if (init_ff == 4'(`VDC_INIT_CYCLES)) begin
                nxt_ready = 1'b1;
            end else begin
                nxt_init = init_ff + 4'h1;
                nxt_op = vdc_pkg::OP_ROW_ONLY_REFRESH;
                nxt_st = vdc_pkg::S_RAS;
                nxt_cnt = 8'(PHASE_CYC);
            end
        end
        // Strobe sequencer: each phase lasts PHASE_CYC+1 cycles.
        if (st_ff != vdc_pkg::S_IDLE) begin
            nxt_cnt = cnt_ff - 8'h01;
            if (cnt_ff == 8'h00) begin
                nxt_cnt = 8'(PHASE_CYC);
                unique case (st_ff)
                    vdc_pkg::S_RAS: begin
                        nxt_ras_n = 1'b0; // Levels were set up one phase earlier.
                        nxt_st = vdc_pkg::S_CAS;
                    end
                    vdc_pkg::S_CAS: begin
                        nxt_cas_n = lv.ras_only || lv.column_first_refresh ? cas_n : 1'b0;
                        nxt_st = vdc_pkg::S_DATA;
                    end
                    vdc_pkg::S_DATA: begin
                        // Data lands at the later of the two falls; reads open late.
                        if (lv.wr) nxt_men_n = 1'b0;
                        if (lv.rd) nxt_trn_n = 1'b0;
                        nxt_st = vdc_pkg::S_END;
                    end
                    vdc_pkg::S_END: begin
                        if (lv.rd) nxt_rd_data = dqi_s2_ff;
                        nxt_ras_n = 1'b1; nxt_cas_n = 1'b1; nxt_trn_n = 1'b1;
                        nxt_men_n = 1'b1; nxt_dqoe_n = 1'b1; nxt_sen_n = 1'b1;
                        if (op_ff == vdc_pkg::OP_READ_XFER) begin
                            nxt_rt_seen = 1'b1;
                            nxt_dir_in = 1'b0;
                        end
                        if (!lv.trn && lv.men == 1'b0) nxt_dir_in = 1'b1;
                        nxt_st = vdc_pkg::S_PRE;
                    end
                    vdc_pkg::S_PRE: nxt_st = vdc_pkg::S_IDLE;
                    default: nxt_st = vdc_pkg::S_IDLE;
                endcase
            end
            if (st_ff == vdc_pkg::S_RAS && cnt_ff == 8'(PHASE_CYC)) begin
                nxt_trn_n = lv.trn; nxt_men_n = lv.men; nxt_fsel = lv.fs_r;
                nxt_sen_n = lv.sen; nxt_cas_n = !lv.column_first_refresh;
                nxt_addr_o = addr_reg_ff[8:0];
                nxt_dq_o = data_reg_ff[`VDC_DATA_MASK_LSB +: 4];
                nxt_dqoe_n = !lv.mask_ras;
            end
            if (st_ff == vdc_pkg::S_CAS && cnt_ff == 8'(PHASE_CYC)) begin
                nxt_addr_o = addr_reg_ff[`VDC_ADDR_COL_LSB +: 9];
                nxt_fsel = lv.fs_c;
                nxt_dq_o = data_reg_ff[3:0];
                nxt_dqoe_n = lv.rd || lv.ras_only || lv.column_first_refresh || !lv.trn;
            end
        end
        // One shift clock per order: enable low stores input or opens output.
        if (sc_busy_ff) begin
            nxt_sc_cnt = sc_cnt_ff - 8'h01;
            if (sc_cnt_ff == 8'(PHASE_CYC)) begin
                nxt_sen_n = !sc_en_ff;
                nxt_sd_o = sc_data_ff;
                nxt_sdoe_n = !(sc_drv_ff && dir_in_ff);
            end
            if (sc_cnt_ff == 8'h00 && !sclk) begin
                nxt_sclk = 1'b1;
                nxt_sin = sdi_s2_ff;
                nxt_sc_cnt = 8'(PHASE_CYC);
            end else if (sc_cnt_ff == 8'h00) begin
                nxt_sclk = 1'b0;
                nxt_sen_n = 1'b1;
                nxt_sdoe_n = 1'b1;
                nxt_sc_busy = 1'b0;
            end
        end
    end

    // Registers; the shift pins float and the buffer is taken as input at reset.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st_ff <= vdc_pkg::S_IDLE; op_ff <= vdc_pkg::OP_ROW_ONLY_REFRESH;
            pwr_ff <= 32'(PWR_CYC); init_ff <= 4'h0; cnt_ff <= 8'h00;
            ready_ff <= 1'b0; rt_seen_ff <= 1'b0; dir_in_ff <= 1'b1;
            refused_ff <= 1'b0; addr_reg_ff <= `VDC_RST_ADDR;
            data_reg_ff <= `VDC_RST_DATA; rd_data_ff <= 4'h0; sin_ff <= 4'h0;
            sc_busy_ff <= 1'b0; sc_en_ff <= 1'b0; sc_drv_ff <= 1'b0;
            sc_cnt_ff <= 8'h00; sc_data_ff <= 4'h0;
            ras_n <= 1'b1; cas_n <= 1'b1; trn_n <= 1'b1; men_n <= 1'b1;
            fsel <= 1'b0; sen_n <= 1'b1; sclk <= 1'b0; dqoe_n <= 1'b1;
            sdoe_n <= 1'b1; addr_o <= 9'h000; dq_o <= 4'h0; sd_o <= 4'h0;
            awr_ff <= 1'b0; bv_ff <= 1'b0; arr_ff <= 1'b0; rv_ff <= 1'b0;
            rdat_ff <= 32'h0000_0000;
        end else begin
            st_ff <= nxt_st; op_ff <= nxt_op; pwr_ff <= nxt_pwr; init_ff <= nxt_init;
            cnt_ff <= nxt_cnt; ready_ff <= nxt_ready; rt_seen_ff <= nxt_rt_seen;
            dir_in_ff <= nxt_dir_in; refused_ff <= nxt_refused;
            addr_reg_ff <= nxt_addr_reg; data_reg_ff <= nxt_data_reg;
            rd_data_ff <= nxt_rd_data; sin_ff <= nxt_sin; sc_busy_ff <= nxt_sc_busy;
            sc_en_ff <= nxt_sc_en; sc_drv_ff <= nxt_sc_drv; sc_cnt_ff <= nxt_sc_cnt;
            sc_data_ff <= nxt_sc_data; ras_n <= nxt_ras_n; cas_n <= nxt_cas_n;
            trn_n <= nxt_trn_n; men_n <= nxt_men_n; fsel <= nxt_fsel;
            sen_n <= nxt_sen_n; sclk <= nxt_sclk; dqoe_n <= nxt_dqoe_n;
            sdoe_n <= nxt_sdoe_n; addr_o <= nxt_addr_o; dq_o <= nxt_dq_o;
            sd_o <= nxt_sd_o; awr_ff <= nxt_awr; bv_ff <= nxt_bv; arr_ff <= nxt_arr;
            rv_ff <= nxt_rv; rdat_ff <= nxt_rdat;
        end
    end

    assign s_axi_awready = awr_ff;
    assign s_axi_wready = awr_ff;
    assign s_axi_bvalid = bv_ff;
    assign s_axi_bresp = 2'h0;
    assign s_axi_arready = arr_ff;
    assign s_axi_rvalid = rv_ff;
    assign s_axi_rresp = 2'h0;
    assign s_axi_rdata = rdat_ff;
    assign row_strobe_n = ras_n;
    assign column_strobe_n = cas_n;
    assign transfer_or_output_enable_n = trn_n;
    assign mask_or_write_enable_n = men_n;
    assign function_select = fsel;
    assign shift_port_enable_n = sen_n;
    assign shift_clock = sclk;
    assign addr = addr_o;
    assign dq_out = dq_o;
    assign dq_oe_n = dqoe_n;
    assign shift_data_out = sd_o;
    assign shift_data_oe_n = sdoe_n;

    // Checks on the pin sequences.
    a_no_early_row: assert property (@(posedge ref_clk) disable iff (!rstn)
        !ready_ff |-> st_ff == vdc_pkg::S_IDLE || op_ff == vdc_pkg::OP_ROW_ONLY_REFRESH)
        else $error("order ran before init");
    a_split_needs_read: assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(ras_n == 1'b0) && op_ff == vdc_pkg::OP_SPLIT_READ_XFER |-> rt_seen_ff)
        else $error("split read before read transfer");
    a_transfer_levels: assert property (@(posedge ref_clk) disable iff (!rstn)
        $fell(ras_n) && op_ff == vdc_pkg::OP_WRITE_XFER |-> !trn_n && !men_n && !sen_n && !fsel)
        else $error("write transfer levels wrong");
    a_dummy_levels: assert property (@(posedge ref_clk) disable iff (!rstn)
        $fell(ras_n) && op_ff == vdc_pkg::OP_DUMMY_WRITE_XFER |-> sen_n && !men_n)
        else $error("dummy write levels wrong");
    a_alt_levels: assert property (@(posedge ref_clk) disable iff (!rstn)
        $fell(ras_n) && op_ff == vdc_pkg::OP_ALT_WRITE_XFER |-> fsel && !men_n && !trn_n)
        else $error("alternate write levels wrong");
    a_mask_on_row: assert property (@(posedge ref_clk) disable iff (!rstn)
        $fell(ras_n) && lv.mask_ras |-> !dqoe_n && dq_o == data_reg_ff[7:4])
        else $error("mask missing at row fall");
    a_block_select: assert property (@(posedge ref_clk) disable iff (!rstn)
        $fell(cas_n) && st_ff == vdc_pkg::S_DATA |-> fsel == lv.fs_c)
        else $error("column select wrong");
    a_write_late: assert property (@(posedge ref_clk) disable iff (!rstn)
        $fell(cas_n) && lv.wr |-> men_n [*4] ##1 !men_n)
        else $error("write enable not after column fall");
    a_read_dir: assert property (@(posedge ref_clk) disable iff (!rstn)
        st_ff == vdc_pkg::S_END && cnt_ff == 8'h00 && op_ff == vdc_pkg::OP_READ_XFER
        |=> !dir_in_ff)
        else $error("direction not output after read transfer");
endmodule
`default_nettype wire

// >>> vdc_cfg.svh
`ifndef VDC_CFG_SVH
`define VDC_CFG_SVH
// Register byte offsets.
`define VDC_OFS_CTRL 5'h00
`define VDC_OFS_ADDR 5'h04
`define VDC_OFS_DATA 5'h08
`define VDC_OFS_STAT 5'h0c
`define VDC_OFS_SHIFT 5'h10
// Field positions.
`define VDC_CTRL_OP_LSB 0
`define VDC_ADDR_COL_LSB 16
`define VDC_DATA_MASK_LSB 4
`define VDC_SHIFT_EN_BIT 4
`define VDC_SHIFT_DRV_BIT 5
// Reset values.
`define VDC_RST_ADDR 32'h0000_0000
`define VDC_RST_DATA 8'h00
// Timing: clock period, strobe phase time, power-up wait, init cycles.
`define VDC_CLK_NS 10
`define VDC_PHASE_NS 30
`define VDC_PHASE_CYC ((`VDC_PHASE_NS + `VDC_CLK_NS - 1) / `VDC_CLK_NS)
`define VDC_PWR_US 100
`define VDC_PWR_CYC ((`VDC_PWR_US * 1000 + `VDC_CLK_NS - 1) / `VDC_CLK_NS)
`define VDC_INIT_CYCLES 8
`endif

// >>> vdc_pkg.sv
package vdc_pkg;
    // Cycle kinds the controller can run on the memory pins.
    typedef enum logic [3:0] {
        OP_ROW_ONLY_REFRESH, OP_COLUMN_FIRST_REFRESH, OP_READ, OP_WRITE,
        OP_ONE_SHOT_MASKED_WRITE, OP_HELD_MASKED_WRITE, OP_BLOCK_FILL,
        OP_ONE_SHOT_MASKED_BLOCK_FILL, OP_HELD_MASKED_BLOCK_FILL,
        OP_LOAD_MASK, OP_LOAD_COLOR, OP_READ_XFER, OP_SPLIT_READ_XFER,
        OP_WRITE_XFER, OP_DUMMY_WRITE_XFER, OP_ALT_WRITE_XFER
    } vdc_op_t;
    // Pin levels and behaviour that one cycle kind needs.
    typedef struct packed {
        logic trn;
        logic men;
        logic fs_r;
        logic fs_c;
        logic sen;
        logic column_first_refresh;
        logic ras_only;
        logic wr;
        logic rd;
        logic mask_ras;
    } vdc_lvl_t;
    typedef enum {S_IDLE, S_RAS, S_CAS, S_DATA, S_END, S_PRE} vdc_state_t;
endpackage

// >>> vdc_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module vdc_dev_model (
    input wire logic row_strobe_n,
    input wire logic column_strobe_n,
    input wire logic transfer_or_output_enable_n,
    input wire logic mask_or_write_enable_n,
    input wire logic function_select,
    input wire logic shift_port_enable_n,
    input wire logic shift_clock,
    input wire logic [8:0] addr,
    input wire logic [3:0] dq_out,
    input wire logic [3:0] shift_data_out,
    output logic [3:0] dq_in,
    output logic [3:0] shift_data_in,
    output logic half_flag,
    output vdc_pkg::vdc_op_t seen_op
);
    bit [3:0] mem [bit [17:0]];
    bit [3:0] shift_buffer [512];
    logic [3:0] msk;
    logic [3:0] clr;
    logic rc, rt, rm, rf, rs, cf, cs, wr, odir, spl;
    logic [8:0] row, col, ptr, tap;
    // Power-up: input direction, lower half; mask and colour stay unknown.
    initial begin
        odir = 1'b0;
        ptr = 9'h000;
        spl = 1'b0;
        dq_in = 4'h0;
        seen_op = vdc_pkg::OP_ROW_ONLY_REFRESH;
    end
    assign half_flag = ptr[8];
    // Undriven serial pins show the inverse so a stale sample cannot match.
    assign shift_data_in = (odir && !shift_port_enable_n) ? shift_buffer[ptr] :
        ~shift_buffer[ptr];
    function automatic logic [3:0] put(input logic [3:0] v, input logic [3:0] o);
        return rm ? v : ((o & ~msk) | (v & msk));
    endfunction
    // Row fall latches the levels that pick the cycle kind.
    always @(negedge row_strobe_n) begin
        {rc, rt, rm, rf, rs} = {column_strobe_n, transfer_or_output_enable_n,
            mask_or_write_enable_n, function_select, shift_port_enable_n};
        row = addr;
        cs = 1'b0;
        wr = 1'b0;
        if (rc && rt && !rm && !rf) msk = dq_out;
    end
    // Column fall loads the tap; a split transfer saves one for the other half.
    always @(negedge column_strobe_n) if (!row_strobe_n) begin
        cf = function_select;
        col = addr;
        cs = 1'b1;
        if (!rt && !(rm && rf)) begin
            for (int i = 0; i < 512; i++) begin
                if (rm) shift_buffer[i] = mem[{row, 9'(i)}];
                else if (rf || !rs) mem[{row, 9'(i)}] = shift_buffer[i];
            end
            ptr = col;
            odir = rm;
            spl = 1'b0;
        end
        if (!rt && rm && rf) {spl, tap} = {1'b1, ~ptr[8], addr[7:0]};
    end
    // Write data is taken at the later of the two falls.
    always @(negedge column_strobe_n or negedge mask_or_write_enable_n)
        if (!row_strobe_n && !column_strobe_n && !mask_or_write_enable_n && rt) begin
            wr = 1'b1;
            if (rm && rf && function_select) clr = dq_out;
            else if (rm && rf) msk = dq_out;
            else if (function_select) for (int i = 0; i < 4; i++) begin
                if (dq_out[i]) mem[{row, addr[8:2], 2'(i)}] =
                    put(clr, mem[{row, addr[8:2], 2'(i)}]);
            end
            else mem[{row, addr}] = put(dq_out, mem[{row, addr}]);
        end
    always @(negedge column_strobe_n or negedge transfer_or_output_enable_n)
        if (!row_strobe_n && !column_strobe_n && !transfer_or_output_enable_n && rt)
            dq_in = mem[{row, col}];
    always @(posedge column_strobe_n) dq_in = ~dq_in;
    // Decoded cycle kind, numbered in the package's enum order.
    always @(posedge row_strobe_n) seen_op = vdc_pkg::vdc_op_t'(!rc ? 1 : !cs ? 0 :
        !rt ? (rm ? (rf ? 12 : 11) : (rf ? 15 : (rs ? 14 : 13))) :
        (rm && rf) ? (cf ? 10 : 9) : rm ? (cf ? 6 : (wr ? 3 : 2)) :
        rf ? (cf ? 8 : 5) : (cf ? 7 : 4));
    always @(posedge shift_clock) begin
        if (!odir && !shift_port_enable_n) shift_buffer[ptr] = shift_data_out;
        if (spl && ptr[7:0] == 8'hff) ptr = tap;
        else ptr = ptr + 9'h001;
    end
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "vdc_cfg.svh"
module testbench;
    logic ref_clk = 1'b0, rstn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, st, rnd = 32'h6cc1;
    logic [3:0] s_axi_wstrb = 4'hf, dq_in, dq_out, shift_data_in, shift_data_out, d, m, c, e;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic row_strobe_n, column_strobe_n, transfer_or_output_enable_n, function_select;
    logic mask_or_write_enable_n, shift_port_enable_n, shift_clock, dq_oe_n;
    logic shift_data_oe_n, half_flag;
    logic [8:0] addr, r, k;
    vdc_pkg::vdc_op_t seen_op;
    int err_count = 0, total_checks = 0, ras_falls = 0;
    vdc_host #(.PWR_CYC(20)) i_vdc_host (.ref_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .row_strobe_n,
        .column_strobe_n, .transfer_or_output_enable_n, .mask_or_write_enable_n,
        .function_select, .shift_port_enable_n, .shift_clock, .addr, .dq_in, .dq_out, .dq_oe_n,
        .shift_data_in, .shift_data_out, .shift_data_oe_n, .half_flag);
    vdc_dev_model i_vdc_dev_model (.row_strobe_n, .column_strobe_n,
        .transfer_or_output_enable_n, .mask_or_write_enable_n, .function_select,
        .shift_port_enable_n, .shift_clock, .addr, .dq_out, .shift_data_out, .dq_in,
        .shift_data_in, .half_flag, .seen_op);
    initial forever #5 ref_clk = ~ref_clk;
    always @(negedge row_strobe_n) ras_falls++;
    function automatic logic [31:0] lf(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic test_done();
        if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        total_checks++;
        if (g !== x) begin
            $display("[FAIL] %s expected %h seen %h", n, x, g);
            err_count++;
        end
    endtask
    // Address and data are offered together; each is dropped once taken.
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        st = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask
    task automatic run(input logic [3:0] op, input logic [8:0] rr, kk, input logic [7:0] v);
        wr(`VDC_OFS_ADDR, {7'h00, kk, 7'h00, rr});
        wr(`VDC_OFS_DATA, {24'h0, v});
        wr(`VDC_OFS_CTRL, {28'h0, op});
        do rd(`VDC_OFS_STAT); while (st[0] !== 1'b0);
    endtask
    task automatic rb(input logic [8:0] rr, kk, input logic [3:0] x);
        run(4'h2, rr, kk, 8'h00);
        chk("read dq", x, st[7:4]);
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        wr(`VDC_OFS_CTRL, 32'hc);
        rd(`VDC_OFS_STAT);
        chk("early refused", 1, st[3]);
        chk("half at start", 0, st[2]);
        do rd(`VDC_OFS_STAT); while (st[1] !== 1'b1);
        chk("init row cycles", 8, ras_falls);
        run(4'hc, 9'h0, 9'h0, 8'h0);
        chk("split refused", 1, st[3]);
        // Every cycle kind once, in enum order, at random places.
        for (int o = 0; o < 16; o++) begin
            rnd = lf(rnd);
            run(4'(o), rnd[8:0], rnd[24:16], rnd[7:0]);
            chk("decoded op", 32'(o), 32'(seen_op));
        end
        rnd = lf(rnd);
        {c, m, d, k, r} = {rnd[31:20], rnd[18:10], rnd[8:0]};
        run(4'h3, r, k, {4'h0, d});
        rb(r, k, d);
        e = (d & ~m) | (c & m);
        run(4'h4, r, k, {m, c});
        rb(r, k, e);
        run(4'h5, r, k, {~m, ~d});
        rb(r, k, (e & ~m) | (~d & m));
        run(4'h9, r, k, {4'h0, 4'hf});
        run(4'ha, r, k, {4'h0, c});
        run(4'h6, r, {k[8:2], 2'b00}, 8'h02);
        rb(r, {k[8:2], 2'b01}, c);
        run(4'h3, r, 9'h0ff, {4'h0, c});
        run(4'hb, r, 9'h0ff, 8'h0);
        wr(`VDC_OFS_SHIFT, 32'h10);
        do rd(`VDC_OFS_STAT); while (st[0] !== 1'b0);
        chk("half after 255", 1, st[2]);
        chk("serial out", c, st[11:8]);
        run(4'he, r, 9'h005, 8'h0);
        wr(`VDC_OFS_SHIFT, {26'h0, 2'b11, ~d});
        do rd(`VDC_OFS_STAT); while (st[0] !== 1'b0);
        run(4'hd, r, 9'h000, 8'h0);
        rb(r, 9'h005, ~d);
        test_done();
    end
    initial begin
        repeat (50000) @(posedge ref_clk);
        err_count++;
        test_done();
    end
endmodule
`default_nettype wire
